//--- core/sar_adc_serial_conversion_ctrl.sv
// Serial control and conversion sequencer of a 12-bit SAR converter
//
// Summary of operation
// RULE1: Span bit picks narrow or wide scale; polarity bit picks unipolar or bipolar.
// RULE2: Control bits are sampled on rising serial clock edges.
// RULE3: When idle with select low, the first high bit is the start bit.
// RULE4: During external clock conversion a start bit is also accepted after bit six is out.
// RULE5: Result bits leave on falling serial clock edges, MSB first.
// RULE6: Unipolar results are straight binary; bipolar results are two's complement.
// RULE7: Select falling alone never starts a conversion; a full byte is needed.
// RULE8: Acquisition starts after the sixth bit and lasts six clock cycles.
// RULE9: A start bit after select falls, before bit six, restarts conversion.
// RULE10: External mode strobe is high one serial clock when acquisition ends.
// RULE11: External mode presents twelve decisions on following falls, then zeros.
// RULE12: External mode: select high floats strobe and data; falling drives them low.
// RULE13: Host should use internal mode for slow or paused serial clocks.
// RULE14: External conversion needs eighteen clocks; host may overlap the next byte.
// RULE15: Host sends eighteen zeros before a byte on a free-running clock.
// RULE16: Internal mode strobe drops after the last control bit, rises when done.
// RULE17: Internal mode: acquisition ends at tick four, conversion at tick sixteen.
// RULE18: Internal mode strobe stays low at most fifteen microseconds.
// RULE19: Internal mode latches result, shows MSB at the end, then shifts out.
// RULE20: Internal mode select high blocks input, floats data, keeps strobe driven.
// RULE21: Host using thirteen clocks waits fifteen microseconds before reading.
// RULE22: Power code 01 runs timing from the serial clock; it always shifts.
// RULE23: Control byte holds start, three channel bits, span, polarity, two mode bits.
// RULE24: Codes 00 internal, 01 external, 10 standby, 11 deep sleep.
// RULE25: After reset: active, internal clock mode, awaiting start, output cleared.
// RULE26: Sleep takes effect after the conversion ends; a start bit wakes.
// RULE27: Select high discards a partial byte and restarts the start search.

`timescale 1ns/1ps
`default_nettype none

`include "sar_ctrl_regs.svh"

module sar_adc_serial_conversion_ctrl
  import sar_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic [11:0] sample_code,
  output logic             dout,
  output logic             dout_oe,
  output logic             conversion_strobe,
  output logic             strobe_oe,
  output logic             track,
  output logic [2:0]       channel_pick,
  output logic             span_select,
  output logic             polarity_select,
  output logic             ext_clock_mode,
  output logic             standby_sleep,
  output logic             deep_sleep
);

  localparam logic [6:0] TICK_LAST = 7'(`TICK_CYC - 1);

  ctl_state_t  q;
  ctl_state_t  n;
  logic        rise;
  logic        fall;
  logic        sel;
  logic        cs_fall;
  logic        int_busy;
  logic        tick;
  logic        six_out;
  logic        start_ok;
  logic        start;
  logic [1:0]  pm;
  logic [11:0] res_code;

  always_comb begin
    n = q;
    pm = q.ctrl[`CB_PM_HI:`CB_PM_LO];

    // Pin synchronisers
    n.cs_s1   = cs_n;
    n.cs_s2   = q.cs_s1;
    n.cs_prev = q.cs_s2;
    n.ck_s1   = sclk;
    n.ck_s2   = q.ck_s1;
    n.ck_prev = q.ck_s2;
    n.di_s1   = din;
    n.di_s2   = q.di_s1;

    rise    = q.ck_s2 & ~q.ck_prev;
    fall    = ~q.ck_s2 & q.ck_prev;
    sel     = ~q.cs_s2;
    cs_fall = q.cs_prev & ~q.cs_s2;

    int_busy = ~q.ext_mode &
               ((q.phase == PH_ACQ) | (q.phase == PH_CONV));
    tick     = int_busy & (q.div == TICK_LAST);
    six_out  = q.pres >= `SIX_OUT_BITS;

    // Bipolar code flips the offset-binary MSB
    res_code = q.setup.pol ?
               {~sample_code[11], sample_code[10:0]} :
               sample_code; // [RULE6] [RULE1]

    // Start search only with select low and outside a byte
    start_ok = (q.phase == PH_IDLE) | // [RULE3]
               ((q.phase != PH_RX) &
                (q.refall | // [RULE9]
                 (q.ext_mode & (q.phase == PH_CONV) &
                  six_out))); // [RULE4] [RULE14]
    start    = sel & rise & q.di_s2 & start_ok; // [RULE2] [RULE7]

    // Internal oscillator runs only during internal acquisition and conversion
    if (int_busy) begin
      n.div = tick ? 7'h00 : q.div + 7'h01;
    end else begin
      n.div = 7'h00;
    end

    if (cs_fall) begin
      n.refall = 1'b1;
    end

    // Output shift; zeros follow the result
    if (fall & ~int_busy) begin
      n.dout = q.res[11]; // [RULE5] [RULE22]
      n.res  = {q.res[10:0], 1'b0}; // [RULE11] [RULE19]
      if (q.pres != `PRES_MAX) begin
        n.pres = q.pres + 4'h1;
      end
    end

    case (q.phase)
      PH_IDLE: begin
      end
      PH_RX: begin
        if (!sel) begin
          n.phase = PH_IDLE; // [RULE27]
          n.track = 1'b0;
        end else begin
          if (rise) begin
            n.ctrl   = {q.ctrl[6:0], q.di_s2}; // [RULE2]
            n.rx_cnt = q.rx_cnt + 4'h1;
          end
          if (fall & q.track) begin
            n.acq_cnt = q.acq_cnt + 4'h1;
          end
          if (fall & ~q.track & (q.rx_cnt == `ACQ_BIT)) begin
            n.track   = 1'b1; // [RULE8]
            n.acq_cnt = 4'h0;
          end
          if (fall & (q.rx_cnt == `CB_BITS)) begin
            n.setup.chan = q.ctrl[`CB_CHAN_HI:`CB_CHAN_LO]; // [RULE23]
            n.setup.span = q.ctrl[`CB_SPAN]; // [RULE1]
            n.setup.pol  = q.ctrl[`CB_POL];
            case (pm)
              `PM_INT: n.ext_mode = 1'b0; // [RULE24]
              `PM_EXT: n.ext_mode = 1'b1; // [RULE22]
              default: n.ext_mode = q.ext_mode;
            endcase
            n.pend_stby = pm == `PM_STBY; // [RULE26]
            n.pend_deep = pm == `PM_DEEP;
            n.tick_cnt  = 5'h00;
            n.phase     = PH_ACQ;
            if (pm == `PM_INT ||
                (pm[`CB_PM_HI] && !q.ext_mode)) begin
              n.strobe = 1'b0; // [RULE16]
            end
          end
        end
      end
      PH_ACQ: begin
        if (q.ext_mode) begin
          if (fall) begin
            n.acq_cnt = q.acq_cnt + 4'h1;
            if (q.acq_cnt == `ACQ_EXT_CLKS - 4'h1) begin
              n.track    = 1'b0; // [RULE8]
              n.strobe   = 1'b1; // [RULE10]
              n.res      = res_code;
              n.pres     = 4'h0;
              n.conv_cnt = 4'h0;
              n.phase    = PH_CONV;
            end
          end
        end else if (tick) begin
          n.tick_cnt = q.tick_cnt + 5'h01;
          if (q.tick_cnt == `INT_ACQ_TCK - 5'h01) begin
            n.track = 1'b0; // [RULE17]
            n.res   = res_code; // [RULE19]
            n.phase = PH_CONV;
          end
        end
      end
      PH_CONV: begin
        if (q.ext_mode) begin
          if (fall) begin
            n.conv_cnt = q.conv_cnt + 4'h1;
            n.strobe   = 1'b0; // [RULE10]
            if (q.conv_cnt == `RES_BITS - 4'h1) begin
              n.phase = PH_IDLE; // [RULE11]
              n.stby  = q.pend_stby; // [RULE26]
              n.deep  = q.pend_deep;
            end
          end
        end else if (tick) begin
          n.tick_cnt = q.tick_cnt + 5'h01;
          if (q.tick_cnt == `INT_DONE_TCK - 5'h01) begin
            n.dout   = q.res[11]; // [RULE19]
            n.res    = {q.res[10:0], 1'b0};
            n.pres   = `PRES_FIRST;
            n.strobe = 1'b1; // [RULE16] [RULE17] [RULE18]
            n.phase  = PH_IDLE;
            n.stby   = q.pend_stby; // [RULE26]
            n.deep   = q.pend_deep;
          end
        end
      end
      default: begin
        n.phase = PH_IDLE;
      end
    endcase

    // External mode drives both pins low after select falls
    if (cs_fall & q.ext_mode) begin
      n.strobe = 1'b0; // [RULE12]
      n.dout   = 1'b0;
    end

    // A start bit abandons whatever was running
    if (start) begin
      n.phase   = PH_RX; // [RULE9]
      n.ctrl    = `CB_START_VAL;
      n.rx_cnt  = `RX_FIRST;
      n.acq_cnt = 4'h0;
      n.track   = 1'b0;
      n.refall  = 1'b0;
      n.stby    = 1'b0; // [RULE26]
      n.deep    = 1'b0;
    end

    n.dout_oe   = sel; // [RULE12] [RULE20]
    n.strobe_oe = sel | ~q.ext_mode; // [RULE12] [RULE20]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0; // [RULE25]
      q.cs_s1   <= `CS_IDLE;
      q.cs_s2   <= `CS_IDLE;
      q.cs_prev <= `CS_IDLE;
    end else begin
      q <= n;
    end
  end

  assign dout              = q.dout;
  assign dout_oe           = q.dout_oe;
  assign conversion_strobe = q.strobe;
  assign strobe_oe         = q.strobe_oe;
  assign track             = q.track;
  assign channel_pick      = q.setup.chan;
  assign span_select       = q.setup.span;
  assign polarity_select   = q.setup.pol;
  assign ext_clock_mode    = q.ext_mode;
  assign standby_sleep     = q.stby;
  assign deep_sleep        = q.deep;

endmodule : sar_adc_serial_conversion_ctrl

`default_nettype wire

//--- core/sar_ctrl_regs.svh
// Constants for the serial conversion controller
`ifndef SAR_CTRL_REGS_SVH
`define SAR_CTRL_REGS_SVH

// Control byte field positions
`define CB_CHAN_HI   6
`define CB_CHAN_LO   4
`define CB_SPAN      3
`define CB_POL       2
`define CB_PM_HI     1
`define CB_PM_LO     0
`define CB_START_VAL 8'h01

// Power mode codes
`define PM_INT       2'h0
`define PM_EXT       2'h1
`define PM_STBY      2'h2
`define PM_DEEP      2'h3

// Bit and clock counts
`define CB_BITS      4'h8
`define RX_FIRST     4'h1
`define ACQ_BIT      4'h6
`define ACQ_EXT_CLKS 4'h6
`define RES_BITS     4'hC
`define SIX_OUT_BITS 4'h6
`define PRES_MAX     4'hF
`define PRES_FIRST   4'h1
`define INT_ACQ_TCK  5'h04
`define INT_DONE_TCK 5'h10

// Internal oscillator timing
`define STRB_MAX_NS  15000
`define SYS_CLK_NS   10
`define TICKS_PER_CV 16
`define TICK_CYC     (`STRB_MAX_NS / `SYS_CLK_NS / `TICKS_PER_CV)

// Reset level of synchronised select
`define CS_IDLE      1'b1

`endif

//--- core/sar_pkg.sv
// Types for the serial conversion controller
package sar_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_RX,
    PH_ACQ,
    PH_CONV
  } phase_t;

  typedef struct packed {
    logic [2:0] chan;
    logic       span;
    logic       pol;
  } setup_t;

  typedef struct packed {
    phase_t      phase;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_prev;
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_prev;
    logic        di_s1;
    logic        di_s2;
    logic        refall;
    logic [7:0]  ctrl;
    logic [3:0]  rx_cnt;
    logic [3:0]  acq_cnt;
    logic [3:0]  conv_cnt;
    logic [4:0]  tick_cnt;
    logic [6:0]  div;
    logic [11:0] res;
    logic [3:0]  pres;
    logic        ext_mode;
    logic        pend_stby;
    logic        pend_deep;
    setup_t      setup;
    logic        dout;
    logic        dout_oe;
    logic        strobe;
    logic        strobe_oe;
    logic        track;
    logic        stby;
    logic        deep;
  } ctl_state_t;

endpackage : sar_pkg

//--- tb/sar_adc_serial_conversion_ctrl_tb.sv
// Self-checking bench for the serial conversion controller
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_conversion_ctrl_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] sample_code = 12'hA5C;
  logic cs_n, sclk, din, dout, dout_oe, conversion_strobe, strobe_oe, track;
  logic span_select, polarity_select, ext_clock_mode;
  logic standby_sleep, deep_sleep;
  logic [2:0] channel_pick;
  int num_errors = 0;
  int n_tests = 0;
  int w;
  always #5 sys_clk = ~sys_clk;
  sar_adc_serial_conversion_ctrl u_sar_adc_serial_conversion_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .sample_code(sample_code), .dout(dout), .dout_oe(dout_oe),
    .conversion_strobe(conversion_strobe), .strobe_oe(strobe_oe),
    .track(track), .channel_pick(channel_pick), .span_select(span_select),
    .polarity_select(polarity_select), .ext_clock_mode(ext_clock_mode),
    .standby_sleep(standby_sleep), .deep_sleep(deep_sleep));
  serial_host u_serial_host (.cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .strobe(conversion_strobe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_done;
    w = 0;
    while (conversion_strobe !== 1'b1 && w < 2000) begin
      @(posedge sys_clk);
      w++;
    end
    check(conversion_strobe, 1'b1);
  endtask : wait_done
  task automatic results;
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    #150us;
    num_errors++;
    results();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check({strobe_oe, ext_clock_mode, standby_sleep, deep_sleep}, 4'h8);
    u_serial_host.frame(8'hD9, 26);
    check({channel_pick, span_select, polarity_select, ext_clock_mode},
      6'b101101);
    check(u_serial_host.rx[12:0], {12'hA5C, 1'b0});
    check(u_serial_host.sb[25:0], 26'h1 << 13);
    u_serial_host.frame(8'hD9, 18);
    u_serial_host.frame(8'hDD, 26);
    check(u_serial_host.rx[12:0], {12'h25C, 1'b0});
    u_serial_host.release_sel();
    check({dout_oe, strobe_oe}, 2'b00);
    u_serial_host.frame(8'h81, 9);
    u_serial_host.release_sel();
    u_serial_host.frame(8'hC1, 4);
    u_serial_host.release_sel();
    u_serial_host.frame(8'hF5, 26);
    check({channel_pick, polarity_select}, 4'hF);
    check(u_serial_host.rx[12:0], {12'h25C, 1'b0});
    u_serial_host.release_sel();
    u_serial_host.frame(8'h8C, 8);
    check({conversion_strobe, ext_clock_mode}, 2'b00);
    u_serial_host.release_sel();
    check({strobe_oe, dout_oe}, 2'b10);
    wait_done();
    check(w inside {[1400:1500]}, 1'b1);
    u_serial_host.frame(8'h00, 12);
    check(u_serial_host.rx[11:0], 12'h25C);
    u_serial_host.frame(8'hDA, 8);
    wait_done();
    repeat (4) @(posedge sys_clk);
    check({standby_sleep, deep_sleep, ext_clock_mode}, 3'b100);
    u_serial_host.frame(8'h8F, 8);
    check(standby_sleep, 1'b0);
    wait_done();
    repeat (4) @(posedge sys_clk);
    check({standby_sleep, deep_sleep, ext_clock_mode}, 3'b010);
    results();
  end
endmodule : sar_adc_serial_conversion_ctrl_tb
`default_nettype wire

//--- tb/sar_ctrl_props.sv
// Port assertions for the serial conversion controller
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_props
  import sar_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic [11:0] sample_code,
  input wire logic        dout,
  input wire logic        dout_oe,
  input wire logic        conversion_strobe,
  input wire logic        strobe_oe,
  input wire logic        track,
  input wire logic        polarity_select,
  input wire logic        ext_clock_mode,
  input wire logic        standby_sleep,
  input wire logic        deep_sleep
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [10:0] held_q;
  // Cycles since acquisition ended
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) held_q <= 11'h000;
    else if ($fell(track)) held_q <= 11'h000;
    else if (held_q != 11'h7FF) held_q <= held_q + 11'h001;
  end
  sequence pulse_s; conversion_strobe[*8]; endsequence
  sequence ext_rise_s; $rose(conversion_strobe) && ext_clock_mode; endsequence
  sequence int_rise_s; $rose(conversion_strobe) && !ext_clock_mode; endsequence
  sel_drive_a: assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
    else $error("data enable late");
  sel_float_a: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
    else $error("data not floated");
  ext_float_a: assert property (
    cs_n[*5] ##0 ext_clock_mode |-> !strobe_oe)
    else $error("strobe driven");
  int_drive_a: assert property (!ext_clock_mode[*3] |-> strobe_oe)
    else $error("strobe floated");
  pulse_len_a: assert property (ext_rise_s |-> pulse_s)
    else $error("strobe pulse short");
  acq_end_a: assert property (ext_rise_s |-> $fell(track))
    else $error("strobe not at hold");
  ext_msb_a: assert property (
    $fell(conversion_strobe) && ext_clock_mode && !cs_n
    |-> dout == (sample_code[11] ^ polarity_select))
    else $error("bad first bit");
  conv_time_a: assert property (
    int_rise_s |-> held_q inside {[11'd1110:11'd1122]})
    else $error("bad conversion time");
  int_msb_a: assert property (
    int_rise_s |-> dout == (sample_code[11] ^ polarity_select))
    else $error("bad result msb");
  sleep_end_a: assert property (
    $rose(standby_sleep) || $rose(deep_sleep) |-> !track)
    else $error("sleep mid conversion");
  one_sleep_a: assert property (!(standby_sleep && deep_sleep))
    else $error("two sleep states");
endmodule : sar_ctrl_props
bind sar_adc_serial_conversion_ctrl sar_ctrl_props u_props (.*);
`default_nettype wire

//--- tb/serial_host.sv
// Behavioural serial master framing control bytes and reading results
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout,
  input  wire logic strobe
);
  localparam realtime HALF = 62.5;
  logic [31:0] rx;
  logic [31:0] sb;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
    rx   = '0;
    sb   = '0;
  end
  // Clock n bits, first eight from cb MSB first; clock idles low after
  task automatic frame(input logic [7:0] cb, input int n);
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      din = (i < 8) ? cb[7 - i] : 1'b0;
      #HALF sclk = 1'b1;
      rx = {rx[30:0], dout};
      sb = {sb[30:0], strobe};
      #HALF sclk = 1'b0;
    end
    #HALF;
  endtask : frame
  task automatic release_sel;
    #HALF cs_n = 1'b1;
    #(4 * HALF);
  endtask : release_sel
endmodule : serial_host
`default_nettype wire
